// file: pcbd_pkg.sv
// Notes on behaviour
// - Drive 24-bit address bus; float it when not bus master.
// - Data moves on a 16-bit bidirectional bus, floated when idle.
// - Only in DMA: make low-byte parity on writes, check it on reads.
// - Drive address strobe low once a valid DMA address is on the bus.
// - Write strobe is input on CPU access, output on DMA writes; the code also drives it, held high, on DMA reads.
// - Assert bus request whenever buses are needed for DMA.
// - Propagated grant output feeds next lower-priority controller's grant input.
// - Grant low means buses granted; floating outputs become active drivers.
// - Assert request-to-send when ready to transmit; hold it while link up.
// - Do not bring the link up before clear-to-send is asserted.
// - Under register select: strobes and six address lines are inputs, ready output.
// - Transmit link data serially on one line.
// - Register selection decoded from address lines one through six.
// - Strap low selects 8-bit bus, high selects 16-bit bus.
package pcbd_pkg;

    localparam int PCBD_AW = 24;
    localparam int PCBD_DW = 16;
    localparam int PCBD_RAW = 6;
    localparam logic [1:0] PCBD_STROBE_CYC = 2'h1;
    localparam int PCBD_TX_BITS = 8;
    localparam logic [3:0] PCBD_TX_LAST = 4'h7;
    localparam logic [PCBD_AW-1:0] PCBD_ADDR_RST = 24'h00_0000;
    localparam logic [PCBD_DW-1:0] PCBD_DATA_RST = 16'h0000;

    typedef enum logic [2:0] {
        PCBD_IDLE,
        PCBD_REQ,
        PCBD_ADDR,
        PCBD_XFER,
        PCBD_DONE
    } pcbd_state_t;

    // One DMA transfer order from the protocol engine
    typedef struct packed {
        logic write;
        logic [PCBD_AW-1:0] addr;
        logic [PCBD_DW-1:0] data;
    } pcbd_dma_cmd_t;

    // Result of one DMA transfer
    typedef struct packed {
        logic [PCBD_DW-1:0] data;
        logic parity_err;
    } pcbd_dma_rsp_t;

    // CPU register access seen through the select port
    typedef struct packed {
        logic write;
        logic [PCBD_RAW-1:0] index;
        logic [PCBD_DW-1:0] data;
    } pcbd_reg_acc_t;

    function automatic logic pcbd_odd_par(input logic [7:0] b);
        return ~(^b);
    endfunction

endpackage

// file: pcbd_tx_ser.sv
`timescale 1ns/1ps
module pcbd_tx_ser
    import pcbd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Byte side
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic link_up,
    output logic tx_ready,
    // Line
    output logic serial_tx_out
);

    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic busy;
    logic next_busy;
    logic line;
    logic next_line;

    always_comb
    begin
        next_shreg = shreg;
        next_cnt = cnt;
        next_busy = busy;
        // Idle line marks high between bytes
        next_line = 1'b1;
        if (busy)
        begin
            next_line = shreg[0];
            next_shreg = {1'b0, shreg[7:1]};
            next_cnt = cnt + 4'h1;
            if (cnt == PCBD_TX_LAST)
                next_busy = 1'b0;
        end
        else if (tx_valid && link_up)
        begin
            next_shreg = tx_byte;
            next_cnt = 4'h0;
            next_busy = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            shreg <= 8'h00;
            cnt <= 4'h0;
            busy <= 1'b0;
            line <= 1'b1;
        end
        else
        begin
            shreg <= next_shreg;
            cnt <= next_cnt;
            busy <= next_busy;
            line <= next_line;
        end
    end

    assign serial_tx_out = line;
    assign tx_ready = ~busy & link_up;

endmodule // pcbd_tx_ser

// file: pcbd_link_hs.sv
`timescale 1ns/1ps
module pcbd_link_hs
    import pcbd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Control
    input wire logic link_enable,
    input wire logic cts_n,
    // Status
    output logic rts_n,
    output logic link_up
);

    logic up;
    logic next_up;
    logic rts;
    logic next_rts;

    always_comb
    begin
        next_rts = link_enable;
        next_up = up;
        if (!link_enable)
            next_up = 1'b0;
        else if (!cts_n)
            next_up = 1'b1;
        else
            // Dropped clear-to-send takes the link down; modem broke its side
            next_up = 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            up <= 1'b0;
            rts <= 1'b0;
        end
        else
        begin
            up <= next_up;
            rts <= next_rts;
        end
    end

    assign rts_n = ~rts;
    assign link_up = up;

endmodule // pcbd_link_hs

// file: pcbd_top.sv
`timescale 1ns/1ps
module pcbd_top
    import pcbd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Strap
    input wire logic bus_width_strap,
    // Address bus
    input wire logic [PCBD_AW-1:0] addr_in,
    output logic [PCBD_AW-1:0] addr_out,
    output logic addr_oe_n,
    // Data bus and parity
    input wire logic [PCBD_DW-1:0] data_in,
    output logic [PCBD_DW-1:0] data_out,
    output logic data_oe_n,
    input wire logic low_byte_parity_in,
    output logic low_byte_parity_out,
    output logic low_byte_parity_oe_n,
    // Strobes
    output logic addr_valid_strobe_n,
    output logic addr_valid_strobe_oe_n,
    input wire logic rd_strobe_n_in,
    output logic rd_strobe_n_out,
    output logic rd_strobe_oe_n,
    input wire logic wr_strobe_n_in,
    output logic wr_strobe_n_out,
    output logic wr_strobe_oe_n,
    // Bus arbitration
    output logic bus_request_n,
    input wire logic bus_grant_n,
    output logic grant_chain_out_n,
    // CPU register port
    input wire logic reg_select_n,
    input wire logic bus_ready_n_in,
    output logic bus_ready_n_out,
    output logic bus_ready_oe_n,
    output pcbd_reg_acc_t reg_acc,
    output logic reg_acc_valid,
    input wire logic [PCBD_DW-1:0] reg_rdata,
    // DMA engine side
    input wire logic dma_valid,
    input wire pcbd_dma_cmd_t dma_cmd,
    output logic dma_ready,
    output pcbd_dma_rsp_t dma_rsp,
    output logic dma_rsp_valid,
    // Link side
    input wire logic link_enable,
    input wire logic cts_n,
    output logic rts_n,
    output logic link_up,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic serial_tx_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture after reset release

    logic wide;
    logic next_wide;
    logic strap_taken;
    logic next_strap_taken;

    always_comb
    begin
        next_strap_taken = 1'b1;
        next_wide = strap_taken ? wide : bus_width_strap;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wide <= 1'b0;
            strap_taken <= 1'b0;
        end
        else
        begin
            wide <= next_wide;
            strap_taken <= next_strap_taken;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA master sequencer

    pcbd_state_t st;
    pcbd_state_t next_st;
    pcbd_dma_cmd_t cmd;
    pcbd_dma_cmd_t next_cmd;
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    logic req;
    logic next_req;
    logic drive;
    logic next_drive;
    logic as_act;
    logic next_as_act;
    logic wr_act;
    logic next_wr_act;
    logic rd_act;
    logic next_rd_act;
    logic next_chain;
    logic rsp_v;
    logic next_rsp_v;
    pcbd_dma_rsp_t rsp;
    pcbd_dma_rsp_t next_rsp;
    logic [PCBD_DW-1:0] rd_mask;

    // Upper byte is driven as zero in 8-bit mode; reads see it as zero
    assign rd_mask = wide ? 16'hFFFF : 16'h00FF;

    always_comb
    begin
        next_st = st;
        next_cmd = cmd;
        next_wait_cnt = wait_cnt;
        next_req = req;
        next_drive = drive;
        next_as_act = as_act;
        next_wr_act = wr_act;
        next_rd_act = rd_act;
        next_rsp_v = 1'b0;
        next_rsp = rsp;
        // Grant not ours passes straight down the chain
        next_chain = (st == PCBD_IDLE) && !req && !bus_grant_n;
        case (st)
            PCBD_IDLE:
            begin
                if (dma_valid && reg_select_n)
                begin
                    next_cmd = dma_cmd;
                    next_req = 1'b1;
                    next_st = PCBD_REQ;
                end
            end
            PCBD_REQ:
            begin
                if (!bus_grant_n)
                begin
                    next_drive = 1'b1;
                    next_st = PCBD_ADDR;
                end
            end
            PCBD_ADDR:
            begin
                // Address has stood one cycle before the strobe falls
                next_as_act = 1'b1;
                next_wr_act = cmd.write;
                next_rd_act = ~cmd.write;
                next_wait_cnt = PCBD_STROBE_CYC;
                next_st = PCBD_XFER;
            end
            PCBD_XFER:
            begin
                if (wait_cnt != 2'h0)
                    next_wait_cnt = wait_cnt - 2'h1;
                else
                begin
                    next_as_act = 1'b0;
                    next_wr_act = 1'b0;
                    next_rd_act = 1'b0;
                    next_req = 1'b0;
                    next_rsp_v = 1'b1;
                    next_rsp.data = cmd.write ? cmd.data : (data_in & rd_mask);
                    next_rsp.parity_err = !cmd.write &&
                        (low_byte_parity_in != pcbd_odd_par(data_in[7:0]));
                    next_st = PCBD_DONE;
                end
            end
            PCBD_DONE:
            begin
                // Drivers release at once; back to idle only after the arbiter lets go of the grant
                next_drive = 1'b0;
                if (bus_grant_n)
                    next_st = PCBD_IDLE;
            end
            default:
            begin
                next_st = PCBD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= PCBD_IDLE;
            cmd <= '0;
            wait_cnt <= 2'h0;
            req <= 1'b0;
            drive <= 1'b0;
            as_act <= 1'b0;
            wr_act <= 1'b0;
            rd_act <= 1'b0;
            rsp_v <= 1'b0;
            rsp <= '0;
        end
        else
        begin
            st <= next_st;
            cmd <= next_cmd;
            wait_cnt <= next_wait_cnt;
            req <= next_req;
            drive <= next_drive;
            as_act <= next_as_act;
            wr_act <= next_wr_act;
            rd_act <= next_rd_act;
            rsp_v <= next_rsp_v;
            rsp <= next_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU register access

    logic cpu_sel;
    logic next_cpu_sel;
    logic acc_v;
    logic next_acc_v;
    pcbd_reg_acc_t acc;
    pcbd_reg_acc_t next_acc;
    logic rdy;
    logic next_rdy;
    logic [PCBD_DW-1:0] cpu_rdata;
    logic [PCBD_DW-1:0] next_cpu_rdata;
    logic cpu_rd_drive;
    logic next_cpu_rd_drive;

    always_comb
    begin
        next_cpu_sel = ~reg_select_n && ~drive;
        next_acc_v = 1'b0;
        next_acc = acc;
        next_rdy = 1'b0;
        next_cpu_rdata = cpu_rdata;
        next_cpu_rd_drive = next_cpu_sel && !rd_strobe_n_in;
        if (next_cpu_sel && (!rd_strobe_n_in || !wr_strobe_n_in) && !rdy)
        begin
            next_acc.write = !wr_strobe_n_in;
            next_acc.index = addr_in[PCBD_RAW:1];
            next_acc.data = data_in & rd_mask;
            next_acc_v = 1'b1;
            next_rdy = 1'b1;
            next_cpu_rdata = reg_rdata & rd_mask;
        end
        else if (rdy && next_cpu_sel && (!rd_strobe_n_in || !wr_strobe_n_in))
            // Ready held until the strobe is released
            next_rdy = 1'b1;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cpu_sel <= 1'b0;
            acc_v <= 1'b0;
            acc <= '0;
            rdy <= 1'b0;
            cpu_rdata <= PCBD_DATA_RST;
            cpu_rd_drive <= 1'b0;
        end
        else
        begin
            cpu_sel <= next_cpu_sel;
            acc_v <= next_acc_v;
            acc <= next_acc;
            rdy <= next_rdy;
            cpu_rdata <= next_cpu_rdata;
            cpu_rd_drive <= next_cpu_rd_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_out <= PCBD_ADDR_RST;
            addr_oe_n <= 1'b1;
            data_out <= PCBD_DATA_RST;
            data_oe_n <= 1'b1;
            low_byte_parity_out <= 1'b0;
            low_byte_parity_oe_n <= 1'b1;
            addr_valid_strobe_n <= 1'b1;
            addr_valid_strobe_oe_n <= 1'b1;
            rd_strobe_n_out <= 1'b1;
            rd_strobe_oe_n <= 1'b1;
            wr_strobe_n_out <= 1'b1;
            wr_strobe_oe_n <= 1'b1;
            bus_request_n <= 1'b1;
            grant_chain_out_n <= 1'b1;
            bus_ready_n_out <= 1'b1;
            bus_ready_oe_n <= 1'b1;
        end
        else
        begin
            addr_out <= cmd.addr;
            addr_oe_n <= ~next_drive;
            // Read data must stand as soon as the bus turns round
            data_out <= next_cpu_rd_drive ? next_cpu_rdata : (cmd.data & rd_mask);
            data_oe_n <= ~((next_drive && next_wr_act) || next_cpu_rd_drive);
            low_byte_parity_out <= pcbd_odd_par(cmd.data[7:0]);
            low_byte_parity_oe_n <= ~(next_drive && next_wr_act);
            addr_valid_strobe_n <= ~next_as_act;
            addr_valid_strobe_oe_n <= ~next_drive;
            rd_strobe_n_out <= ~next_rd_act;
            rd_strobe_oe_n <= ~next_drive;
            wr_strobe_n_out <= ~next_wr_act;
            wr_strobe_oe_n <= ~next_drive;
            bus_request_n <= ~next_req;
            grant_chain_out_n <= ~next_chain;
            bus_ready_n_out <= ~next_rdy;
            bus_ready_oe_n <= ~next_cpu_sel;
        end
    end

    assign reg_acc = acc;
    assign reg_acc_valid = acc_v;
    assign dma_ready = (st == PCBD_IDLE) && !req;
    assign dma_rsp = rsp;
    assign dma_rsp_valid = rsp_v;

    ////////////////////////////////////////////////////////////////////////////
    // Link handshake and serial transmit

    pcbd_link_hs u_link (.mclk(mclk), .rstn(rstn), .link_enable(link_enable), .cts_n(cts_n),
        .rts_n(rts_n), .link_up(link_up));
    pcbd_tx_ser u_tx (.mclk(mclk), .rstn(rstn), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .link_up(link_up), .tx_ready(tx_ready), .serial_tx_out(serial_tx_out));

endmodule // pcbd_top

// file: pcbd_monitor.sv
`timescale 1ns/1ps
module pcbd_monitor
    import pcbd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // System bus
    input wire logic [PCBD_AW-1:0] addr_out,
    input wire logic addr_oe_n,
    input wire logic [PCBD_DW-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic low_byte_parity_out,
    input wire logic low_byte_parity_oe_n,
    input wire logic addr_valid_strobe_n,
    input wire logic rd_strobe_n_in,
    input wire logic rd_strobe_oe_n,
    input wire logic wr_strobe_n_in,
    input wire logic wr_strobe_oe_n,
    // Arbitration
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic grant_chain_out_n,
    // CPU port and engine
    input wire logic reg_select_n,
    input wire logic bus_ready_n_out,
    input wire logic bus_ready_oe_n,
    input wire logic reg_acc_valid,
    input wire logic dma_rsp_valid,
    // Link
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic link_up
);
    default clocking c_main @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_dma_walk;
        !addr_oe_n ##1 !addr_valid_strobe_n [*2]
        ##1 (addr_valid_strobe_n && bus_request_n && dma_rsp_valid);
    endsequence
    sequence s_cpu_start;
        $fell(rd_strobe_n_in && wr_strobe_n_in) && !reg_select_n && addr_oe_n;
    endsequence

    property p_dma_walk;
        $fell(bus_grant_n) && !bus_request_n |=> s_dma_walk;
    endproperty
    property p_master_only;
        !addr_oe_n |-> !bus_grant_n;
    endproperty
    property p_release;
        $rose(bus_request_n) |=> addr_oe_n && data_oe_n && low_byte_parity_oe_n && rd_strobe_oe_n;
    endproperty
    property p_strobe_addr;
        !addr_valid_strobe_n |-> !addr_oe_n && $stable(addr_out);
    endproperty
    property p_parity;
        !data_oe_n && !addr_oe_n |->
            !low_byte_parity_oe_n && (low_byte_parity_out == ~(^data_out[7:0]));
    endproperty
    property p_select_in;
        !reg_select_n && !$past(reg_select_n) |-> rd_strobe_oe_n && wr_strobe_oe_n && addr_oe_n;
    endproperty
    property p_cpu_ready;
        s_cpu_start |=> reg_acc_valid && !bus_ready_oe_n ##1 !bus_ready_n_out;
    endproperty
    property p_chain;
        !grant_chain_out_n |-> !$past(bus_grant_n) && $past(bus_request_n);
    endproperty
    property p_cts_first;
        $rose(link_up) |-> !$past(cts_n);
    endproperty
    property p_rts;
        link_up |-> !rts_n;
    endproperty

    ////////////////////////////////////////////////////////////////////////////////
    a_dma_walk: assert property (p_dma_walk) else $error("dma walk broken");
    a_master_only: assert property (p_master_only) else $error("address driven ungranted");
    a_release: assert property (p_release) else $error("bus not floated");
    a_strobe_addr: assert property (p_strobe_addr) else $error("strobe without address");
    a_parity: assert property (p_parity) else $error("bad write parity");
    a_select_in: assert property (p_select_in) else $error("driving under select");
    a_cpu_ready: assert property (p_cpu_ready) else $error("cpu access not answered");
    a_chain: assert property (p_chain) else $error("grant passed wrongly");
    a_cts_first: assert property (p_cts_first) else $error("link up before cts");
    a_rts: assert property (p_rts) else $error("rts high while link up");
endmodule // pcbd_monitor

bind pcbd_top pcbd_monitor u_mon (.*);

// file: pcbd_host_model.sv
`timescale 1ns/1ps
module pcbd_host_model
    import pcbd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Scenario controls
    input wire logic [3:0] grant_delay,
    input wire logic force_grant,
    input wire logic bad_parity,
    // Bus
    input wire logic bus_request_n,
    input wire logic [PCBD_AW-1:0] addr_bus,
    input wire logic addr_valid_strobe_n,
    input wire logic rd_bus_n,
    output logic bus_grant_n,
    output logic [PCBD_DW-1:0] host_data,
    output logic host_parity
);
    logic [3:0] wait_cnt;
    logic [PCBD_DW-1:0] stale;
    logic reading;
    logic [PCBD_DW-1:0] mem_word;

    // Released bus keeps toggling so a stale sample never matches
    assign reading = !addr_valid_strobe_n && !rd_bus_n;
    assign mem_word = addr_bus[15:0] ^ 16'h5A3C;
    assign host_data = reading ? mem_word : stale;
    assign host_parity = reading ? (~(^mem_word[7:0]) ^ bad_parity) : ~stale[0];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_cnt <= 4'h0;
            bus_grant_n <= 1'b1;
            stale <= 16'h0000;
        end
        else
        begin
            stale <= reading ? ~mem_word : ~stale;
            if (bus_request_n)
            begin
                wait_cnt <= 4'h0;
                bus_grant_n <= !force_grant;
            end
            else if (wait_cnt >= grant_delay)
                bus_grant_n <= 1'b0;
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // pcbd_host_model

// file: pcbd_top_tb.sv
`timescale 1ns/1ps
module pcbd_top_tb
    import pcbd_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b1;
    logic [PCBD_AW-1:0] cpu_addr = 24'h00_0000;
    logic [PCBD_DW-1:0] cpu_data = 16'h0000;
    logic cpu_rd_n = 1'b1;
    logic cpu_wr_n = 1'b1;
    logic sel_n = 1'b1;
    logic [PCBD_DW-1:0] reg_rdata = 16'hC3A5;
    logic dma_valid = 1'b0;
    pcbd_dma_cmd_t dma_cmd = '0;
    logic link_enable = 1'b0;
    logic cts_n = 1'b1;
    logic tx_valid = 1'b0;
    logic [7:0] tx_byte = 8'h2C;
    logic [3:0] grant_delay = 4'h0;
    logic force_grant = 1'b0;
    logic bad_parity = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    logic [PCBD_AW-1:0] addr_out, seen_addr;
    logic [PCBD_DW-1:0] data_out, host_data, seen_data;
    logic addr_oe_n, data_oe_n, par_out, par_oe_n, avs_n, rd_out, rd_oe_n, wr_out, wr_oe_n;
    logic bus_request_n, bus_grant_n, chain_n, ready_out, ready_oe_n, reg_acc_valid;
    logic dma_ready, dma_rsp_valid, rts_n, link_up, tx_ready, serial_tx_out, host_parity;
    logic seen_wr, seen_par;
    pcbd_reg_acc_t reg_acc;
    pcbd_dma_rsp_t dma_rsp, rsp;
    // Bus wires by enable
    wire [PCBD_AW-1:0] addr_w = !addr_oe_n ? addr_out : cpu_addr;
    wire [PCBD_DW-1:0] data_w = !data_oe_n ? data_out : (cpu_wr_n ? host_data : cpu_data);
    wire par_w = !par_oe_n ? par_out : host_parity;
    wire rd_w = !rd_oe_n ? rd_out : cpu_rd_n;
    wire wr_w = !wr_oe_n ? wr_out : cpu_wr_n;

    pcbd_top dut (.mclk(mclk), .rstn(rstn), .bus_width_strap(strap), .addr_in(addr_w),
        .addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_in(data_w), .data_out(data_out),
        .data_oe_n(data_oe_n), .low_byte_parity_in(par_w), .low_byte_parity_out(par_out),
        .low_byte_parity_oe_n(par_oe_n), .addr_valid_strobe_n(avs_n),
        .addr_valid_strobe_oe_n(), .rd_strobe_n_in(rd_w), .rd_strobe_n_out(rd_out),
        .rd_strobe_oe_n(rd_oe_n), .wr_strobe_n_in(wr_w), .wr_strobe_n_out(wr_out),
        .wr_strobe_oe_n(wr_oe_n), .bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n),
        .grant_chain_out_n(chain_n), .reg_select_n(sel_n), .bus_ready_n_in(1'b1),
        .bus_ready_n_out(ready_out), .bus_ready_oe_n(ready_oe_n), .reg_acc(reg_acc),
        .reg_acc_valid(reg_acc_valid), .reg_rdata(reg_rdata), .dma_valid(dma_valid),
        .dma_cmd(dma_cmd), .dma_ready(dma_ready), .dma_rsp(dma_rsp),
        .dma_rsp_valid(dma_rsp_valid), .link_enable(link_enable), .cts_n(cts_n),
        .rts_n(rts_n), .link_up(link_up), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .serial_tx_out(serial_tx_out));
    pcbd_host_model u_host (.mclk(mclk), .rstn(rstn), .grant_delay(grant_delay),
        .force_grant(force_grant), .bad_parity(bad_parity), .bus_request_n(bus_request_n),
        .addr_bus(addr_out), .addr_valid_strobe_n(avs_n), .rd_bus_n(rd_w),
        .bus_grant_n(bus_grant_n), .host_data(host_data), .host_parity(host_parity));

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Polls at falling edges
    task automatic wait_lvl(input string what, ref logic sig, input logic lvl);
        for (int i = 0; i < 64 && sig !== lvl; i++)
            @(negedge mclk);
        if (sig !== lvl)
        begin
            chk(what, lvl, sig);
            tally_and_finish();
        end
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic dma_op(input logic w, input logic [23:0] a, input logic [15:0] d);
        @(posedge mclk);
        dma_valid <= 1'b1;
        dma_cmd <= '{write: w, addr: a, data: d};
        @(negedge mclk);
        wait_lvl("dma_ready", dma_ready, 1'b1);
        @(posedge mclk);
        dma_valid <= 1'b0;
        @(negedge mclk);
        wait_lvl("addr_valid_strobe_n", avs_n, 1'b0);
        seen_addr = addr_w;
        seen_data = data_w;
        seen_wr = wr_w;
        seen_par = par_w;
        wait_lvl("dma_rsp_valid", dma_rsp_valid, 1'b1);
        rsp = dma_rsp;
        wait_lvl("bus_request_n", bus_request_n, 1'b1);
        wait_lvl("bus_grant_n", bus_grant_n, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_dma_write();
        dma_op(1'b1, 24'hA5_1234, 16'h12F7);
        chk("dma address", 24'hA5_1234, seen_addr);
        chk("dma write data", 24'h00_12F7, seen_data);
        chk("dma write parity", 1'b0, seen_par);
        chk("dma write strobe", 1'b0, seen_wr);
        $display("test dma write done");
    endtask

    task automatic t_dma_read();
        grant_delay <= 4'h5;
        dma_op(1'b0, 24'h03_00F0, 16'h0000);
        chk("dma read data", 16'h00F0 ^ 16'h5A3C, rsp.data);
        chk("parity error clean", 1'b0, rsp.parity_err);
        bad_parity <= 1'b1;
        dma_op(1'b0, 24'h03_00F2, 16'h0000);
        chk("parity error flagged", 1'b1, rsp.parity_err);
        bad_parity <= 1'b0;
        grant_delay <= 4'h0;
        $display("test dma read done");
    endtask

    task automatic t_chain();
        force_grant <= 1'b1;
        @(negedge mclk);
        wait_lvl("grant_chain_out_n low", chain_n, 1'b0);
        chk("no own request", 1'b1, bus_request_n);
        force_grant <= 1'b0;
        wait_lvl("grant_chain_out_n high", chain_n, 1'b1);
        $display("test chain done");
    endtask

    task automatic cpu_acc(input logic w, input logic [23:0] a, input logic [5:0] idx);
        @(posedge mclk);
        sel_n <= 1'b0;
        cpu_addr <= a;
        cpu_data <= 16'hBEEF;
        cpu_rd_n <= w;
        cpu_wr_n <= !w;
        @(negedge mclk);
        wait_lvl("reg_acc_valid", reg_acc_valid, 1'b1);
        chk("register index", idx, reg_acc.index);
        chk("register write flag", w, reg_acc.write);
        if (w)
            chk("register write data", 16'hBEEF, reg_acc.data);
        wait_lvl("bus_ready_n_out", ready_out, 1'b0);
        if (!w)
            chk("register read data", reg_rdata, data_w);
        @(posedge mclk);
        cpu_rd_n <= 1'b1;
        cpu_wr_n <= 1'b1;
        sel_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_cpu();
        int hits;
        cpu_acc(1'b0, 24'h00_002A, 6'h15);
        cpu_acc(1'b1, 24'h00_007E, 6'h3F);
        hits = 0;
        @(posedge mclk);
        cpu_rd_n <= 1'b0;
        repeat (6) @(negedge mclk) hits += reg_acc_valid;
        cpu_rd_n <= 1'b1;
        chk("access without select", 0, hits);
        $display("test cpu done");
    endtask

    task automatic t_link();
        logic [7:0] rx;
        link_enable <= 1'b1;
        repeat (4) @(negedge mclk);
        chk("rts_n", 1'b0, rts_n);
        chk("link without cts", 1'b0, link_up);
        cts_n <= 1'b0;
        wait_lvl("link_up", link_up, 1'b1);
        @(posedge mclk);
        tx_valid <= 1'b1;
        @(negedge mclk);
        wait_lvl("tx_ready", tx_ready, 1'b1);
        @(posedge mclk);
        tx_valid <= 1'b0;
        @(negedge mclk);
        wait_lvl("serial first bit", serial_tx_out, 1'b0);
        for (int i = 0; i < PCBD_TX_BITS; i++)
        begin
            rx[i] = serial_tx_out;
            @(negedge mclk);
        end
        chk("serial byte", 8'h2C, rx);
        cts_n <= 1'b1;
        wait_lvl("link down", link_up, 1'b0);
        $display("test link done");
    endtask

    task automatic t_width8();
        strap <= 1'b0;
        do_reset();
        dma_op(1'b0, 24'h00_1357, 16'h0000);
        chk("narrow read data", (16'h1357 ^ 16'h5A3C) & 16'h00FF, rsp.data);
        $display("test narrow bus done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        t_dma_write();
        t_dma_read();
        t_chain();
        t_cpu();
        t_link();
        t_width8();
        tally_and_finish();
    end
endmodule // pcbd_top_tb
